//--- pkg/rimc_pkg.sv
package rimc_pkg;

  // register offsets (byte addresses on the plain port)
  localparam logic [6:0] OFS_IRQ_EN_PKT  = 7'h05;
  localparam logic [6:0] OFS_IRQ_EN_SYS  = 7'h06;
  localparam logic [6:0] OFS_MODE_CTL_A  = 7'h07;
  localparam logic [6:0] OFS_MODE_CTL_B  = 7'h08;
  localparam logic [6:0] OFS_STAT_PKT    = 7'h03;
  localparam logic [6:0] OFS_STAT_SYS    = 7'h04;

  // reset values
  localparam logic [7:0] RST_IRQ_EN_PKT  = 8'h00;
  localparam logic [7:0] RST_IRQ_EN_SYS  = 8'h03;
  localparam logic [7:0] RST_MODE_CTL_A  = 8'h01;
  localparam logic [7:0] RST_MODE_CTL_B  = 8'h00;

  // host-writable bits of the second enable register
  localparam logic [7:0] SYS_EN_WR_MASK  = 8'h0f;

  // field positions, control register a
  localparam int BIT_SW_RESET   = 7;
  localparam int BIT_BATT_MON   = 6;
  localparam int BIT_WAKE_TMR   = 5;
  localparam int BIT_SLOW_OSC   = 4;
  localparam int BIT_TX_ON      = 3;
  localparam int BIT_RX_ON      = 2;
  localparam int BIT_SYNTH_ON   = 1;
  localparam int BIT_XTAL_ON    = 0;
  // field position, control register b
  localparam int BIT_MULTI_PKT  = 4;
  // field position, low-battery status bit
  localparam int BIT_LOW_BATT   = 2;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rimc_bus_req_t;

  typedef struct packed {
    logic battery_monitor_on;
    logic wake_timer_on;
    logic slow_osc_select;
    logic tx_on;
    logic rx_on;
    logic synth_on;
    logic xtal_on;
  } rimc_mode_t;

endpackage : rimc_pkg

//--- logic/rimc_regs.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps

// Function
// - enable bit 7 of first register gates fifo underflow/overflow event
// - bits 6 and 5 gate tx fifo almost-full and almost-empty events
// - bit 4 gates rx fifo almost-full event
// - bit 3 gates external interrupt event
// - bit 2 gates packet-sent event
// - bit 1 gates valid-packet-received event
// - bit 0 gates rx crc error event
// - second register bit 7 enables sync-word detect, read-only to host
// - bit 6 enables valid-preamble detect, read-only to host
// - bit 5 enables invalid-preamble detect, read-only to host
// - bit 4 enables signal-strength-above-threshold, read-only to host
// - host-writable bit 3 enables wake-timer expiry interrupt
// - host-writable bit 2 enables low-battery interrupt
// - host-writable bits 1 and 0 enable chip-ready and power-on interrupts
// - writing control bit 7 resets the enable and control registers (not the status registers), then clears itself
// - control bit 6 turns on battery monitor
// - control bit 5 enables wake timer, running in every mode
// - control bit 4 picks slow time base: 0 rc, 1 crystal
// - control bit 3 starts transmit, self-clears when packet sent
// - control bit 2 starts receive, self-clears on valid packet unless multi-packet
// - control bit 1 keeps synthesizer on while idle
// - control bit 0 selects ready mode, crystal kept on
// - enabled rising status drives irq low; status read releases, clears enabled bits
// - disabled status bits other than low battery are plain status, not cleared by reading
// - low-battery event latched while disabled, interrupts once enabled
module rimc_regs
  import rimc_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  // register port
  input  wire logic [6:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // radio events, same clock domain, level status sources
  input  wire logic [7:0] pkt_event_in,
  input  wire logic [7:0] sys_event_in,
  // radio core handshakes
  input  wire logic       packet_sent_in,
  input  wire logic       packet_valid_in,
  // mode and interrupt outputs
  output rimc_mode_t      mode_out,
  output logic            irq_request_n_out
);

  rimc_bus_req_t req;
  logic [7:0] en_pkt_ff, en_sys_ff, ctl_a_ff, ctl_b_ff;
  logic [7:0] st_pkt_ff, st_sys_ff, prev_pkt_ff, prev_sys_ff;
  logic [7:0] rdata_ff;
  logic       irq_ff;
  logic       soft_rst;
  logic       rd_pkt, rd_sys;
  logic [7:0] rise_pkt, rise_sys;
  logic [7:0] nxt_st_pkt, nxt_st_sys;
  logic       nxt_irq;

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // reset of the enable and control registers takes effect on the edge after the write
  assign soft_rst = req.wr && req.addr == OFS_MODE_CTL_A && req.wdata[BIT_SW_RESET];
  assign rd_pkt   = req.rd && req.addr == OFS_STAT_PKT;
  assign rd_sys   = req.rd && req.addr == OFS_STAT_SYS;

  // enable registers
  always_ff @(posedge ref_clk_in) begin
    if (reset_in || soft_rst) begin
      en_pkt_ff <= RST_IRQ_EN_PKT;
      en_sys_ff <= RST_IRQ_EN_SYS;
    end else if (req.wr) begin
      if (req.addr == OFS_IRQ_EN_PKT) begin
        en_pkt_ff <= req.wdata;
      end
      if (req.addr == OFS_IRQ_EN_SYS) begin
        // upper nibble is read-only and keeps its value
        en_sys_ff <= (en_sys_ff & ~SYS_EN_WR_MASK) | (req.wdata & SYS_EN_WR_MASK);
      end
    end
  end

  // control register a, with self-clearing start bits
  always_ff @(posedge ref_clk_in) begin
    if (reset_in || soft_rst) begin
      ctl_a_ff <= RST_MODE_CTL_A;
    end else begin
      if (req.wr && req.addr == OFS_MODE_CTL_A) begin
        ctl_a_ff <= req.wdata;
      end
      // hardware clear wins over a same-cycle host write
      if (packet_sent_in) begin
        ctl_a_ff[BIT_TX_ON] <= 1'b0;
      end
      if (packet_valid_in && !ctl_b_ff[BIT_MULTI_PKT]) begin
        ctl_a_ff[BIT_RX_ON] <= 1'b0;
      end
    end
  end

  // control register b, stored only
  always_ff @(posedge ref_clk_in) begin
    if (reset_in || soft_rst) begin
      ctl_b_ff <= RST_MODE_CTL_B;
    end else if (req.wr && req.addr == OFS_MODE_CTL_B) begin
      ctl_b_ff <= req.wdata;
    end
  end

  // status latching: rising edge sets, read clears only enabled bits; set wins
  assign rise_pkt = pkt_event_in & ~prev_pkt_ff;
  assign rise_sys = sys_event_in & ~prev_sys_ff;

  always_comb begin
    nxt_st_pkt = st_pkt_ff;
    nxt_st_sys = st_sys_ff;
    if (rd_pkt) begin
      nxt_st_pkt = st_pkt_ff & ~en_pkt_ff;
    end
    if (rd_sys) begin
      nxt_st_sys = st_sys_ff & ~en_sys_ff;
    end
    // disabled bits track the live level; low battery is always latched
    nxt_st_pkt = (nxt_st_pkt & en_pkt_ff) | (pkt_event_in & ~en_pkt_ff) | rise_pkt;
    nxt_st_sys = (nxt_st_sys & en_sys_ff) | (sys_event_in & ~en_sys_ff) | rise_sys;
    // latched on the rise only, so a read can clear it while the level stays high
    nxt_st_sys[BIT_LOW_BATT] = rise_sys[BIT_LOW_BATT]
                             | (st_sys_ff[BIT_LOW_BATT] & ~(rd_sys & en_sys_ff[BIT_LOW_BATT]));
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      st_pkt_ff   <= 8'h00;
      st_sys_ff   <= 8'h00;
      prev_pkt_ff <= 8'h00;
      prev_sys_ff <= 8'h00;
    end else begin
      st_pkt_ff   <= nxt_st_pkt;
      st_sys_ff   <= nxt_st_sys;
      prev_pkt_ff <= pkt_event_in;
      prev_sys_ff <= sys_event_in;
    end
  end

  // irq: any enabled latched bit holds the line low
  assign nxt_irq = |(nxt_st_pkt & en_pkt_ff) || |(nxt_st_sys & en_sys_ff);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  assign irq_request_n_out = ~irq_ff;

  // read port, data one cycle after the strobe
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rdata_ff <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        OFS_IRQ_EN_PKT: rdata_ff <= en_pkt_ff;
        OFS_IRQ_EN_SYS: rdata_ff <= en_sys_ff;
        OFS_MODE_CTL_A: rdata_ff <= ctl_a_ff;
        OFS_MODE_CTL_B: rdata_ff <= ctl_b_ff;
        OFS_STAT_PKT:   rdata_ff <= st_pkt_ff;
        OFS_STAT_SYS:   rdata_ff <= st_sys_ff;
        default:        rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign rdata_out = rdata_ff;

  // mode outputs straight from the control flops
  assign mode_out.battery_monitor_on = ctl_a_ff[BIT_BATT_MON];
  assign mode_out.wake_timer_on      = ctl_a_ff[BIT_WAKE_TMR];
  assign mode_out.slow_osc_select    = ctl_a_ff[BIT_SLOW_OSC];
  assign mode_out.tx_on              = ctl_a_ff[BIT_TX_ON];
  assign mode_out.rx_on              = ctl_a_ff[BIT_RX_ON];
  assign mode_out.synth_on           = ctl_a_ff[BIT_SYNTH_ON];
  assign mode_out.xtal_on            = ctl_a_ff[BIT_XTAL_ON];

  // assertions
  property p_ro_bits_hold;
    @(posedge ref_clk_in) disable iff (reset_in)
      (req.wr && req.addr == OFS_IRQ_EN_SYS && !soft_rst) |=> en_sys_ff[7:4] == $past(en_sys_ff[7:4]);
  endproperty
  a_ro_bits_hold: assert property (p_ro_bits_hold) else $error("read-only enable bits changed");

  property p_sw_bits_write;
    @(posedge ref_clk_in) disable iff (reset_in)
      (req.wr && req.addr == OFS_IRQ_EN_SYS) |=> en_sys_ff[3:0] == $past(req.wdata[3:0]);
  endproperty
  a_sw_bits_write: assert property (p_sw_bits_write) else $error("writable enable bits wrong");

  property p_pkt_en_write;
    @(posedge ref_clk_in) disable iff (reset_in)
      (req.wr && req.addr == OFS_IRQ_EN_PKT) |=> en_pkt_ff == $past(req.wdata);
  endproperty
  a_pkt_en_write: assert property (p_pkt_en_write) else $error("first enable register not stored");

  property p_soft_reset;
    @(posedge ref_clk_in) disable iff (reset_in)
      soft_rst |=> ctl_a_ff == RST_MODE_CTL_A && en_pkt_ff == RST_IRQ_EN_PKT;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("software reset did not restore defaults");

  property p_tx_clear;
    @(posedge ref_clk_in) disable iff (reset_in) packet_sent_in |=> !mode_out.tx_on;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("tx start not cleared");

  property p_rx_clear;
    @(posedge ref_clk_in) disable iff (reset_in)
      (packet_valid_in && !ctl_b_ff[BIT_MULTI_PKT] && !soft_rst) |=> !mode_out.rx_on;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx start not cleared");

  property p_irq_on_rise;
    @(posedge ref_clk_in) disable iff (reset_in)
      |(rise_pkt & en_pkt_ff) |=> !irq_request_n_out;
  endproperty
  a_irq_on_rise: assert property (p_irq_on_rise) else $error("enabled event did not raise irq");

  property p_lbd_latched;
    @(posedge ref_clk_in) disable iff (reset_in)
      (rise_sys[BIT_LOW_BATT] && !en_sys_ff[BIT_LOW_BATT]) ##1 (!rd_sys [*2]) |-> st_sys_ff[BIT_LOW_BATT];
  endproperty
  a_lbd_latched: assert property (p_lbd_latched) else $error("low battery event lost");

  property p_read_data;
    @(posedge ref_clk_in) disable iff (reset_in)
      (req.rd && req.addr == OFS_MODE_CTL_B) |=> rdata_out == $past(ctl_b_ff);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong");

  // per-bit gating of the first enable register onto the irq line
  property p_gate_fifo_err;
    @(posedge ref_clk_in) disable iff (reset_in)
      (rise_pkt[7] && en_pkt_ff[7]) |=> !irq_request_n_out;
  endproperty
  a_gate_fifo_err: assert property (p_gate_fifo_err) else $error("fifo error event not gated to irq");

  property p_gate_tx_full;
    @(posedge ref_clk_in) disable iff (reset_in)
      ((rise_pkt[6] && en_pkt_ff[6]) || (rise_pkt[5] && en_pkt_ff[5])) |=> !irq_request_n_out;
  endproperty
  a_gate_tx_full: assert property (p_gate_tx_full) else $error("tx fifo event not gated to irq");

  property p_gate_rx_full;
    @(posedge ref_clk_in) disable iff (reset_in)
      (rise_pkt[4] && en_pkt_ff[4]) |=> !irq_request_n_out;
  endproperty
  a_gate_rx_full: assert property (p_gate_rx_full) else $error("rx fifo event not gated to irq");

  property p_gate_ext;
    @(posedge ref_clk_in) disable iff (reset_in)
      (rise_pkt[3] && en_pkt_ff[3]) |=> !irq_request_n_out;
  endproperty
  a_gate_ext: assert property (p_gate_ext) else $error("external event not gated to irq");

  property p_gate_sent;
    @(posedge ref_clk_in) disable iff (reset_in)
      (rise_pkt[2] && en_pkt_ff[2]) |=> !irq_request_n_out;
  endproperty
  a_gate_sent: assert property (p_gate_sent) else $error("packet sent event not gated to irq");

  property p_gate_valid;
    @(posedge ref_clk_in) disable iff (reset_in)
      (rise_pkt[1] && en_pkt_ff[1]) |=> !irq_request_n_out;
  endproperty
  a_gate_valid: assert property (p_gate_valid) else $error("valid packet event not gated to irq");

  property p_gate_crc;
    @(posedge ref_clk_in) disable iff (reset_in)
      (rise_pkt[0] && en_pkt_ff[0]) |=> !irq_request_n_out;
  endproperty
  a_gate_crc: assert property (p_gate_crc) else $error("crc error event not gated to irq");

  // second enable register: read-only upper nibble, host-writable bits 3 and 2
  property p_ro_sync;
    @(posedge ref_clk_in) disable iff (reset_in)
      (req.wr && req.addr == OFS_IRQ_EN_SYS) |=> en_sys_ff[7] == $past(en_sys_ff[7]);
  endproperty
  a_ro_sync: assert property (p_ro_sync) else $error("sync enable bit written");

  property p_ro_pre_ok;
    @(posedge ref_clk_in) disable iff (reset_in)
      (req.wr && req.addr == OFS_IRQ_EN_SYS) |=> en_sys_ff[6] == $past(en_sys_ff[6]);
  endproperty
  a_ro_pre_ok: assert property (p_ro_pre_ok) else $error("valid preamble enable bit written");

  property p_ro_pre_bad;
    @(posedge ref_clk_in) disable iff (reset_in)
      (req.wr && req.addr == OFS_IRQ_EN_SYS) |=> en_sys_ff[5] == $past(en_sys_ff[5]);
  endproperty
  a_ro_pre_bad: assert property (p_ro_pre_bad) else $error("invalid preamble enable bit written");

  property p_ro_level;
    @(posedge ref_clk_in) disable iff (reset_in)
      (req.wr && req.addr == OFS_IRQ_EN_SYS) |=> en_sys_ff[4] == $past(en_sys_ff[4]);
  endproperty
  a_ro_level: assert property (p_ro_level) else $error("signal level enable bit written");

  property p_wr_wake;
    @(posedge ref_clk_in) disable iff (reset_in)
      (req.wr && req.addr == OFS_IRQ_EN_SYS) |=> en_sys_ff[3] == $past(req.wdata[3]);
  endproperty
  a_wr_wake: assert property (p_wr_wake) else $error("wake timer enable not stored");

  property p_wr_batt;
    @(posedge ref_clk_in) disable iff (reset_in)
      (req.wr && req.addr == OFS_IRQ_EN_SYS) |=> en_sys_ff[BIT_LOW_BATT] == $past(req.wdata[BIT_LOW_BATT]);
  endproperty
  a_wr_batt: assert property (p_wr_batt) else $error("low battery enable not stored");

  // disabled bits simply follow their source level
  property p_plain_status;
    @(posedge ref_clk_in) disable iff (reset_in)
      (en_pkt_ff == 8'h00) |=> st_pkt_ff == $past(pkt_event_in);
  endproperty
  a_plain_status: assert property (p_plain_status) else $error("disabled status not plain");

  // mode outputs follow a host write of control register a
  property p_mode_batt;
    @(posedge ref_clk_in) disable iff (reset_in)
      (req.wr && req.addr == OFS_MODE_CTL_A && !req.wdata[BIT_SW_RESET])
      |=> mode_out.battery_monitor_on == $past(req.wdata[BIT_BATT_MON]);
  endproperty
  a_mode_batt: assert property (p_mode_batt) else $error("battery monitor mode wrong");

  property p_mode_wake;
    @(posedge ref_clk_in) disable iff (reset_in)
      (req.wr && req.addr == OFS_MODE_CTL_A && !req.wdata[BIT_SW_RESET])
      |=> mode_out.wake_timer_on == $past(req.wdata[BIT_WAKE_TMR]);
  endproperty
  a_mode_wake: assert property (p_mode_wake) else $error("wake timer mode wrong");

  property p_mode_slow;
    @(posedge ref_clk_in) disable iff (reset_in)
      (req.wr && req.addr == OFS_MODE_CTL_A && !req.wdata[BIT_SW_RESET])
      |=> mode_out.slow_osc_select == $past(req.wdata[BIT_SLOW_OSC]);
  endproperty
  a_mode_slow: assert property (p_mode_slow) else $error("slow time base select wrong");

  property p_mode_tx;
    @(posedge ref_clk_in) disable iff (reset_in)
      (req.wr && req.addr == OFS_MODE_CTL_A && !req.wdata[BIT_SW_RESET] && !packet_sent_in)
      |=> mode_out.tx_on == $past(req.wdata[BIT_TX_ON]);
  endproperty
  a_mode_tx: assert property (p_mode_tx) else $error("tx start not stored");

  property p_mode_rx;
    @(posedge ref_clk_in) disable iff (reset_in)
      (req.wr && req.addr == OFS_MODE_CTL_A && !req.wdata[BIT_SW_RESET] && !packet_valid_in)
      |=> mode_out.rx_on == $past(req.wdata[BIT_RX_ON]);
  endproperty
  a_mode_rx: assert property (p_mode_rx) else $error("rx start not stored");

  property p_mode_synth;
    @(posedge ref_clk_in) disable iff (reset_in)
      (req.wr && req.addr == OFS_MODE_CTL_A && !req.wdata[BIT_SW_RESET])
      |=> mode_out.synth_on == $past(req.wdata[BIT_SYNTH_ON]);
  endproperty
  a_mode_synth: assert property (p_mode_synth) else $error("synthesizer mode wrong");

  property p_mode_xtal;
    @(posedge ref_clk_in) disable iff (reset_in)
      (req.wr && req.addr == OFS_MODE_CTL_A && !req.wdata[BIT_SW_RESET])
      |=> mode_out.xtal_on == $past(req.wdata[BIT_XTAL_ON]);
  endproperty
  a_mode_xtal: assert property (p_mode_xtal) else $error("ready mode wrong");

  c_irq_fire:  cover property (@(posedge ref_clk_in) disable iff (reset_in) $fell(irq_request_n_out));
  c_irq_clear: cover property (@(posedge ref_clk_in) disable iff (reset_in) rd_pkt ##1 $rose(irq_request_n_out));
  c_soft_rst:  cover property (@(posedge ref_clk_in) disable iff (reset_in) soft_rst);
  c_tx_done:   cover property (@(posedge ref_clk_in) disable iff (reset_in) mode_out.tx_on ##1 !mode_out.tx_on);

endmodule : rimc_regs

//--- test/rimc_host_model.sv
`timescale 1ns/1ps
module rimc_host_model
  import rimc_pkg::*;
(
  // clock
  input  wire logic       ref_clk_in,
  // register port
  output logic      [6:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out,
  input  wire logic [7:0] rdata_in
);
  initial begin
    addr_out  = 7'h00;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end
  // can abort a send by writing tx_on low in control register a
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge ref_clk_in);
    wr_out    <= 1'b0;
    wdata_out <= ~d;
  endtask : wr
  // data only stands in the cycle after the strobe
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge ref_clk_in);
    rd_out   <= 1'b0;
    #1;
    d = rdata_in;
  endtask : rd
endmodule : rimc_host_model

//--- test/radio_irq_enable_and_mode_control_tb_top.sv
`timescale 1ns/1ps
module radio_irq_enable_and_mode_control_tb_top;
  import rimc_pkg::*;
  logic       ref_clk_in = 1'b0;
  logic       reset_in   = 1'b1;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [7:0] pkt_ev = 8'h00;
  logic [7:0] sys_ev = 8'h00;
  logic       wr, rd, irq_n;
  logic       sent  = 1'b0;
  logic       valid = 1'b0;
  rimc_mode_t mode;
  int         err_total = 0;
  int         tests_run = 0;
  int         seed = 73990;
  int         n;
  logic [7:0] n_rd;
  function automatic logic [7:0] exp_sys_en(input logic [7:0] x);
    return (RST_IRQ_EN_SYS & ~SYS_EN_WR_MASK) | (x & SYS_EN_WR_MASK);
  endfunction : exp_sys_en
  always #25 ref_clk_in = ~ref_clk_in;
  rimc_host_model host_u (.ref_clk_in(ref_clk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
                          .rd_out(rd), .rdata_in(rdata));
  rimc_regs dut_u (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .addr_in(addr), .wdata_in(wdata),
                   .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .pkt_event_in(pkt_ev), .sys_event_in(sys_ev),
                   .packet_sent_in(sent), .packet_valid_in(valid), .mode_out(mode),
                   .irq_request_n_out(irq_n));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("tests_run %0d err_total %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_in);
    #1;
  endtask : tick
  task automatic irq_bit(input logic [6:0] en_a, input logic [6:0] st_a, input int b, input logic sys);
    logic [7:0] m;
    logic [7:0] s;
    m = 8'h01 << b;
    host_u.wr(en_a, m);
    @(posedge ref_clk_in);
    if (sys) sys_ev <= m;
    else pkt_ev <= m;
    tick(1);
    check({7'h00, irq_n}, 8'h00, "irq low");
    host_u.rd(st_a, s);
    check(s & m, m, "status bit");
    check({7'h00, irq_n}, 8'h01, "irq release");
    @(posedge ref_clk_in);
    pkt_ev <= 8'h00;
    sys_ev <= 8'h00;
  endtask : irq_bit
  task automatic pulse(input logic tx);
    @(posedge ref_clk_in);
    if (tx) sent <= 1'b1;
    else valid <= 1'b1;
    @(posedge ref_clk_in);
    sent  <= 1'b0;
    valid <= 1'b0;
    tick(1);
  endtask : pulse
  task automatic defaults_ok(input string msg);
    host_u.rd(OFS_IRQ_EN_PKT, d);
    check(d, RST_IRQ_EN_PKT, msg);
    host_u.rd(OFS_IRQ_EN_SYS, d);
    check(d, RST_IRQ_EN_SYS, msg);
    host_u.rd(OFS_MODE_CTL_A, d);
    check(d, RST_MODE_CTL_A, msg);
    host_u.rd(OFS_MODE_CTL_B, d);
    check(d, RST_MODE_CTL_B, msg);
  endtask : defaults_ok
  initial begin
    repeat (8) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    defaults_ok("reset value");
    host_u.rd(7'h7f, d);
    check(d, 8'h00, "unmapped read");
    $display("test reset done");
    repeat (8) begin
      d = 8'($random(seed));
      host_u.wr(OFS_IRQ_EN_PKT, d);
      host_u.rd(OFS_IRQ_EN_PKT, n_rd);
      check(n_rd, d, "pkt en");
      host_u.wr(OFS_IRQ_EN_SYS, d);
      host_u.rd(OFS_IRQ_EN_SYS, n_rd);
      check(n_rd, exp_sys_en(d), "sys en");
      host_u.wr(OFS_MODE_CTL_A, d & 8'h7f);
      tick(1);
      check({1'b0, mode}, d & 8'h7f, "mode out");
      host_u.rd(OFS_MODE_CTL_A, n_rd);
      check(n_rd, d & 8'h7f, "ctl a");
    end
    $display("test random rw done");
    host_u.wr(OFS_IRQ_EN_SYS, 8'h00);
    for (int i = 0; i < 8; i++) irq_bit(OFS_IRQ_EN_PKT, OFS_STAT_PKT, i, 1'b0);
    for (int i = 0; i < 4; i++) irq_bit(OFS_IRQ_EN_SYS, OFS_STAT_SYS, i, 1'b1);
    host_u.wr(OFS_IRQ_EN_PKT, 8'h00);
    @(posedge ref_clk_in);
    pkt_ev <= 8'h81;
    tick(2);
    check({7'h00, irq_n}, 8'h01, "masked irq");
    repeat (2) begin
      host_u.rd(OFS_STAT_PKT, d);
      check(d, 8'h81, "plain status");
    end
    @(posedge ref_clk_in);
    pkt_ev <= 8'h00;
    $display("test irq done");
    host_u.wr(OFS_IRQ_EN_SYS, 8'h00);
    @(posedge ref_clk_in);
    sys_ev <= 8'h01 << BIT_LOW_BATT;
    @(posedge ref_clk_in);
    sys_ev <= 8'h00;
    tick(3);
    check({7'h00, irq_n}, 8'h01, "lbd masked");
    host_u.wr(OFS_IRQ_EN_SYS, 8'h01 << BIT_LOW_BATT);
    for (n = 0; n < 8 && irq_n !== 1'b0; n++) tick(1);
    check({7'h00, irq_n}, 8'h00, "lbd late irq");
    if (n == 8) test_done();
    host_u.rd(OFS_STAT_SYS, d);
    $display("test low battery done");
    host_u.wr(OFS_MODE_CTL_B, 8'h00);
    host_u.wr(OFS_MODE_CTL_A, 8'h0c);
    pulse(1'b1);
    check({6'h00, mode.tx_on, mode.rx_on}, 8'h01, "tx self clear");
    pulse(1'b0);
    check({7'h00, mode.rx_on}, 8'h00, "rx self clear");
    host_u.wr(OFS_MODE_CTL_B, 8'h01 << BIT_MULTI_PKT);
    host_u.wr(OFS_MODE_CTL_A, 8'h04);
    pulse(1'b0);
    check({7'h00, mode.rx_on}, 8'h01, "rx multi packet");
    $display("test mode done");
    host_u.wr(OFS_IRQ_EN_PKT, 8'hff);
    host_u.wr(OFS_MODE_CTL_B, 8'hff);
    host_u.wr(OFS_MODE_CTL_A, 8'h80);
    defaults_ok("soft reset");
    $display("test soft reset done");
    test_done();
  end
endmodule : radio_irq_enable_and_mode_control_tb_top
